// >>> rtl/ebms_consts.svh
// constants of the external bus mode sequencer: offsets, field positions,
// reset values and cycle counts; included by the sequencer module
`ifndef EBMS_CONSTS_SVH
`define EBMS_CONSTS_SVH
// apb byte offsets
`define EBMS_OFF_DCFG    8'h00
`define EBMS_OFF_WCFG    8'h04
`define EBMS_OFF_WADR    8'h14
`define EBMS_OFF_CTRL    8'h24
`define EBMS_OFF_STAT    8'h28
// configuration register fields
`define EBMS_B_ACT       10
`define EBMS_B_BSW       9
`define EBMS_B_WIDE      7
`define EBMS_B_MUX       6
`define EBMS_B_RWD       5
// reset values
`define EBMS_DCFG_SINGLE 16'h00c0
// cycle counts
`define EBMS_CMD_CYC     3'd4
`define EBMS_STRAP_CYC   3'd5
`endif

// >>> rtl/ebms_pkg.sv
// types shared by the external bus mode sequencer and its bench
// assumes nothing of its surroundings
package ebms_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_CMD  = 4'b1000
  } ebms_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        word;
    logic [15:0] wdata;
  } ebms_req_t;
endpackage

// >>> rtl/ebms_top.sv
// external bus mode sequencer: window match, mode select, cycle strobes
// assumes one clock pclk, apb master for registers, cpu holds a request
`timescale 1ns/100ps
`default_nettype none
`include "ebms_consts.svh"
module ebms_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              req_valid,
  input  wire ebms_pkg::ebms_req_t req,
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic      [15:0]       rsp_rdata,
  input  wire logic              irq_entry,
  output logic                   csp_save,
  output logic                   illegal_bus_trap,
  input  wire logic              external_access_pin,
  input  wire logic [15:0]       multiplexed_port_i,
  output logic      [15:0]       multiplexed_port_o,
  output logic      [1:0]        multiplexed_port_oe,
  output logic      [15:0]       address_port_o,
  output logic                   address_port_oe,
  output logic      [5:0]        seg_addr_o,
  output logic      [3:0]        cs_n_o,
  output logic                   ale_o,
  output logic                   rd_n_o,
  output logic                   write_low_strobe_n,
  output logic                   write_high_strobe_n
);
  import ebms_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] cfg_q [0:4];
  logic [15:0] wadr_q [0:3];
  logic        seg_dis_q, strap_done_q;
  logic [2:0]  strap_cnt_q;
  logic [1:0]  sls_q, css_q;
  logic [16:0] s1_q, s2_q, s3_q, sync_q;
  ebms_state_t st_q;
  logic [2:0]  cnt_q, len_q, win_q, last_win_q;
  logic [1:0]  ext_q;
  logic [15:0] cur_q, wdata_q, rdat_q;
  logic [23:0] addr_q;
  logic        wr_q, word_q, phase_q, last_bsw_q, have_last_q, prev_demux_q;

  // ----------------------------------------------------------------
  // pin synchronisers and strap fields
  // ----------------------------------------------------------------
  wire [16:0] sync_d = (s2_q & s3_q) | (sync_q & (s2_q ^ s3_q)); // settled value counts this edge
  wire [15:0] din    = sync_d[15:0];
  wire        ea_st  = sync_q[16];

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= 17'h0;
      s2_q   <= 17'h0;
      s3_q   <= 17'h0;
      sync_q <= 17'h0;
    end else begin
      s1_q   <= {external_access_pin, multiplexed_port_i};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      sync_q <= sync_d;
    end
  end

  // ----------------------------------------------------------------
  // window match and mode selection
  // ----------------------------------------------------------------
  logic [3:0] hit;
  logic [4:0] dm;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_cfg
      assign dm[gi] = cfg_q[gi][`EBMS_B_ACT] & ~cfg_q[gi][`EBMS_B_MUX];
      if (gi < 4) begin : g_win
        wire [11:0] msk = 12'hfff << wadr_q[gi][3:0];
        // window hit: base in bits 15:4, size code 4K << bits 3:0
        assign hit[gi] = cfg_q[gi+1][`EBMS_B_ACT] &
                         (((req.addr[23:12] ^ wadr_q[gi][15:4]) & msk) == 12'h0);
      end
    end
  endgenerate

  // lowest window wins, gaps fall to the default config
  wire [2:0]  win      = hit[0] ? 3'd1 : hit[1] ? 3'd2 : hit[2] ? 3'd3 :
                         hit[3] ? 3'd4 : 3'd0;
  wire [15:0] sel_cfg  = cfg_q[win];
  wire        any_dmx  = |dm;
  wire        take     = (st_q == ST_IDLE) & strap_done_q & req_valid & ~rsp_valid;
  wire        cmd_end  = (st_q == ST_CMD) & (cnt_q == `EBMS_CMD_CYC - 3'd1);
  wire        addr_end = (st_q == ST_ADDR) & (cnt_q == len_q - 3'd1);
  wire        cur_mux  = cur_q[`EBMS_B_MUX];
  wire        cur_wide = cur_q[`EBMS_B_WIDE];
  wire        split    = cmd_end & ~cur_wide & word_q & ~phase_q;
  wire        launch   = (take & sel_cfg[`EBMS_B_ACT]) | split;
  wire        enter_cmd = (addr_end & ~cur_mux) | (st_q == ST_HOLD);
  // extra address cycles: mux after demux, and leaving a switch-wait window
  wire        dly_mux  = sel_cfg[`EBMS_B_MUX] & prev_demux_q;
  wire        dly_sw   = last_bsw_q & have_last_q & (win != last_win_q);
  wire [1:0]  ext_n    = take ? ({1'b0, dly_mux} + {1'b0, dly_sw}) : 2'd0;
  wire [15:0] l_cfg    = take ? sel_cfg : cur_q;
  wire [23:0] l_addr   = take ? req.addr : {addr_q[23:1], 1'b1};
  wire [2:0]  l_len    = 3'd1 + {1'b0, ext_n} +
                         {2'b0, ~l_cfg[`EBMS_B_MUX] & l_cfg[`EBMS_B_RWD]};
  wire [5:0]  seg_msk  = (sls_q == 2'b11) ? 6'h03 : (sls_q == 2'b10) ? 6'h3f :
                         (sls_q == 2'b01) ? 6'h00 : 6'h0f;
  wire [3:0]  cs_msk   = (css_q == 2'b11) ? 4'hf : (css_q == 2'b10) ? 4'h0 :
                         (css_q == 2'b01) ? 4'h3 : 4'h7;
  wire [3:0]  cs_one   = (win < 3'd4) ? (4'h1 << win[1:0]) : 4'h0;
  // read data assembly, low byte first on an 8-bit bus
  wire [15:0] cap_d    = cur_wide ? (word_q ? din :
                         {8'h0, addr_q[0] ? din[15:8] : din[7:0]}) :
                         (phase_q ? {din[7:0], rdat_q[7:0]} : {8'h0, din[7:0]});

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  wire [7:0]  wofs   = paddr - `EBMS_OFF_WADR;
  wire        al     = (paddr[1:0] == 2'b00);
  wire        cfg_h  = al & (paddr < `EBMS_OFF_WADR);
  wire        wadr_h = al & (paddr >= `EBMS_OFF_WADR) & (paddr < `EBMS_OFF_CTRL);
  wire        ctrl_h = (paddr == `EBMS_OFF_CTRL);
  wire        stat_h = (paddr == `EBMS_OFF_STAT);
  wire        mapped = cfg_h | wadr_h | ctrl_h | stat_h;
  wire        apb_wr = psel & penable & pwrite & pready & mapped;
  wire [31:0] stat_v = {23'h0, ea_st, css_q, sls_q, last_win_q, st_q != ST_IDLE};
  wire [31:0] rd_mux = cfg_h  ? {16'h0, cfg_q[paddr[4:2]]} :
                       wadr_h ? {16'h0, wadr_q[wofs[3:2]]} :
                       ctrl_h ? {31'h0, seg_dis_q} : stat_h ? stat_v : 32'h0;

  // register writes and the reset strap load of the default config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) cfg_q[i] <= 16'h0;
      for (int i = 0; i < 4; i++) wadr_q[i] <= 16'h0;
      seg_dis_q    <= 1'b0;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= 3'd0;
      sls_q        <= 2'b00;
      css_q        <= 2'b00;
      prdata       <= 32'h0;
      pslverr      <= 1'b0;
      pready       <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel & ~penable) begin
        prdata  <= rd_mux;
        pslverr <= ~mapped;
      end
      if (!strap_done_q) begin
        strap_cnt_q <= strap_cnt_q + 3'd1;
        if (strap_cnt_q == `EBMS_STRAP_CYC - 3'd1) begin
          strap_done_q <= 1'b1;
          sls_q        <= din[10:9];
          css_q        <= din[12:11];
          cfg_q[0]     <= ea_st ? `EBMS_DCFG_SINGLE :
                          ((16'h1 << `EBMS_B_ACT) | {8'h0, din[7:6], 6'h0});
        end
      end else if (apb_wr) begin
        if (cfg_h) cfg_q[paddr[4:2]] <= pwdata[15:0];
        if (wadr_h) wadr_q[wofs[3:2]] <= pwdata[15:0];
        if (ctrl_h) seg_dis_q <= pwdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      {cnt_q, len_q, win_q, last_win_q, ext_q} <= 14'h0;
      {cur_q, wdata_q, rdat_q} <= 48'h0;
      addr_q <= 24'h0;
      {wr_q, word_q, phase_q, last_bsw_q, have_last_q, prev_demux_q} <= 6'h0;
      {rsp_valid, rsp_err, csp_save, illegal_bus_trap} <= 4'h0;
      rsp_rdata <= 16'h0;
      multiplexed_port_o  <= 16'h0;
      multiplexed_port_oe <= 2'b00;
      address_port_o      <= 16'h0;
      address_port_oe     <= 1'b0;
      seg_addr_o          <= 6'h0;
      cs_n_o              <= 4'hf;
      ale_o               <= 1'b0;
      rd_n_o              <= 1'b1;
      write_low_strobe_n  <= 1'b1;
      write_high_strobe_n <= 1'b1;
    end else begin
      rsp_valid        <= 1'b0;
      illegal_bus_trap <= 1'b0;
      csp_save         <= irq_entry & ~seg_dis_q;
      address_port_oe  <= any_dmx;
      seg_addr_o       <= seg_dis_q ? 6'h0 : (addr_q[21:16] & seg_msk);
      // start of a byte or word cycle; config frozen for its length
      if (launch) begin
        st_q           <= ST_ADDR;
        cnt_q          <= 3'd0;
        cur_q          <= l_cfg;
        addr_q         <= l_addr;
        len_q          <= l_len;
        ext_q          <= ext_n;
        address_port_o <= l_addr[15:0];
        ale_o          <= l_cfg[`EBMS_B_MUX];
        multiplexed_port_o  <= l_addr[15:0];
        multiplexed_port_oe <= (l_cfg[`EBMS_B_MUX] & (ext_n == 2'd0)) ? 2'b11 : 2'b00;
        if (take) begin
          {wr_q, word_q, wdata_q} <= {req.write, req.word, req.wdata};
          win_q   <= win;
          phase_q <= 1'b0;
          rdat_q  <= 16'h0;
          cs_n_o  <= ~(cs_one & cs_msk);
        end else begin
          phase_q <= 1'b1;
        end
      end
      // command phase: strobe and drive write data
      if (enter_cmd) begin
        cnt_q  <= 3'd0;
        st_q   <= ST_CMD;
        rd_n_o <= wr_q;
        write_low_strobe_n  <= ~(wr_q & (~cur_wide | word_q | ~addr_q[0]));
        write_high_strobe_n <= ~(wr_q & cur_wide & (word_q | addr_q[0]));
        multiplexed_port_o  <= cur_wide ? (word_q ? wdata_q :
                               {wdata_q[7:0], wdata_q[7:0]}) :
                               {addr_q[15:8], phase_q ? wdata_q[15:8] : wdata_q[7:0]};
        multiplexed_port_oe <= wr_q ? ((cur_wide | cur_mux) ? 2'b11 : 2'b01) :
                               ((~cur_wide & cur_mux) ? 2'b10 : 2'b00);
      end
      // end of command: capture read data while strobe still low
      if (cmd_end) begin
        rd_n_o              <= 1'b1;
        write_low_strobe_n  <= 1'b1;
        write_high_strobe_n <= 1'b1;
        rdat_q              <= cap_d;
        if (!wr_q) multiplexed_port_oe <= 2'b00;
      end
      if (!launch) begin
        case (st_q)
          ST_IDLE: begin
            if (take) begin
              illegal_bus_trap <= 1'b1;
              rsp_valid        <= 1'b1;
              rsp_err          <= 1'b1;
            end
          end
          ST_ADDR: begin
            if (addr_end) begin
              ale_o <= 1'b0;
              if (cur_mux) st_q <= ST_HOLD;
            end else begin
              cnt_q <= cnt_q + 3'd1;
              // delayed address goes out once the extra cycles pass
              if (cur_mux & ({1'b0, ext_q} <= cnt_q + 3'd1))
                multiplexed_port_oe <= 2'b11;
            end
          end
          ST_HOLD: ;
          ST_CMD: begin
            if (cmd_end) begin
              st_q         <= ST_IDLE;
              rsp_valid    <= 1'b1;
              rsp_err      <= 1'b0;
              rsp_rdata    <= cap_d;
              last_win_q   <= win_q;
              last_bsw_q   <= cur_q[`EBMS_B_BSW];
              have_last_q  <= 1'b1;
              prev_demux_q <= ~cur_mux;
            end else begin
              cnt_q <= cnt_q + 3'd1;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  bus_active_a: assert property (rsp_valid && !rsp_err |-> cur_q[`EBMS_B_ACT])
    else $error("cycle ran without bus active");
  trap_resp_a: assert property (illegal_bus_trap |-> rsp_valid && rsp_err)
    else $error("trap without error answer");
  strobe_ale_a: assert property ((!rd_n_o || !write_low_strobe_n) |-> !ale_o)
    else $error("command strobe overlaps latch strobe");
  read_len_a: assert property ($fell(rd_n_o) |-> !rd_n_o [*4] ##1 rd_n_o)
    else $error("read strobe not four cycles");
  write_hold_a: assert property ($rose(write_low_strobe_n) && !$past(launch) |=>
      multiplexed_port_oe[0] && $stable(multiplexed_port_o[7:0]))
    else $error("write data dropped after strobe");
  addr_port_a: assert property (any_dmx |=> address_port_oe)
    else $error("address port idle with demux config");
  mux_delay_a: assert property (launch && take && dly_mux && !dly_sw |=>
      ale_o && multiplexed_port_oe == 2'b00 ##1 ale_o && multiplexed_port_oe == 2'b11)
    else $error("mux address not delayed one clock");
  switch_wait_a: assert property (launch && take && dly_sw &&
      !sel_cfg[`EBMS_B_MUX] |=> (st_q == ST_ADDR) [*2])
    else $error("switch wait missing");
  seg_off_a: assert property ($past(seg_dis_q) |-> seg_addr_o == 6'h0)
    else $error("segment lines active while disabled");
  csp_gate_a: assert property (csp_save |-> $past(irq_entry) && !$past(seg_dis_q))
    else $error("pointer save while segmentation disabled");
  cfg_hold_a: assert property (st_q != ST_IDLE && !launch |=> $stable(cur_q))
    else $error("config changed inside a cycle");
  split_a: assert property (rsp_valid && !rsp_err && word_q && !cur_wide |-> phase_q)
    else $error("word on byte bus not split");
endmodule
`default_nettype wire

// >>> tb/ebms_ext_mem.sv
// byte memory standing on the parallel bus of the sequencer
// assumes straps are wanted only while strap_en is high
`timescale 1ns/100ps
`default_nettype none
module ebms_ext_mem (
  input  wire logic        strap_en,
  input  wire logic [15:0] strap,
  input  wire logic [15:0] mux_o,
  input  wire logic [15:0] adr_o,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wrl_n,
  input  wire logic        wrh_n,
  output logic      [15:0] din
);
  logic [7:0]  mem [256];
  logic [7:0]  la;
  logic        mux_cyc = 1'b0;
  logic [15:0] last    = 16'h5a5a;
  wire  [7:0]  a       = mux_cyc ? la : adr_o[7:0];
  wire  [15:0] mux_d;
  wire  [7:0]  a_d;
  // late copies: the next cycle may launch at the edge that ends a strobe
  assign #1 mux_d = mux_o;
  assign #1 a_d = a;
  // address caught by the falling latch strobe
  always @(negedge ale) begin
    la = mux_o[7:0];
    mux_cyc = 1'b1;
  end
  // byte lanes stored as each write strobe ends
  always @(posedge wrl_n) mem[a_d] = mux_d[7:0];
  always @(posedge wrh_n) mem[a_d | 8'h01] = mux_d[15:8];
  // forget the latched address once the command is over
  always @(posedge rd_n or posedge wrl_n or posedge wrh_n) #1 mux_cyc = 1'b0;
  always @(posedge rd_n) last = {mem[a_d | 8'h01], mem[a_d]};
  // straps, read data, or a changed value once released
  always @* begin
    if (strap_en) din = strap;
    else if (!rd_n) din = {mem[a | 8'h01], mem[a]};
    else din = ~last;
  end
endmodule
`default_nettype wire

// >>> tb/ebms_top_test.sv
// self-checking bench of the external bus mode sequencer
// assumes the external memory model and the design files alongside
`timescale 1ns/100ps
`default_nettype none
`include "ebms_consts.svh"
module ebms_top_test;
  import ebms_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rq, r;
  logic pready, pslverr, re, rsp_valid, rsp_err, csp_save, trap, ale;
  logic req_valid = 0, irq = 0, ea = 1, strap_en = 1, wd;
  ebms_req_t req = '0;
  logic [15:0] rsp_rdata, din, mux_o, adr_o, adr_seen;
  logic [1:0] mux_oe;
  logic aoe, aoe_seen, rd_n, wrl_n, wrh_n;
  logic [5:0] seg;
  logic [3:0] cs_n;
  logic [23:0] a;
  int fails = 0, comparisons = 0, cyc = 0, traps = 0, ale_run = 0, ale_len = 0;
  int seed = 32'hcba109e9;
  ebms_top ebms_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .irq_entry(irq), .csp_save(csp_save),
    .illegal_bus_trap(trap), .external_access_pin(ea), .multiplexed_port_i(din),
    .multiplexed_port_o(mux_o), .multiplexed_port_oe(mux_oe), .address_port_o(adr_o),
    .address_port_oe(aoe), .seg_addr_o(seg), .cs_n_o(cs_n), .ale_o(ale), .rd_n_o(rd_n),
    .write_low_strobe_n(wrl_n), .write_high_strobe_n(wrh_n));
  ebms_ext_mem ebms_ext_mem_inst (.strap_en(strap_en), .strap(16'h04c0), .mux_o(mux_o),
    .adr_o(adr_o), .ale(ale), .rd_n(rd_n), .wrl_n(wrl_n), .wrh_n(wrh_n), .din(din));
  // --------------------------------------------------------------
  // clock, timeout and bus monitor
  // --------------------------------------------------------------
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // cycle ceiling: a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  // latch strobe length and address port seen while it is high
  always @(posedge pclk) begin
    if (ale) begin
      ale_run <= ale_run + 1;
      adr_seen <= adr_o;
      aoe_seen <= aoe;
    end else if (ale_run != 0) begin
      ale_len <= ale_run;
      ale_run <= 0;
    end
    if (trap) traps <= traps + 1;
  end
  // --------------------------------------------------------------
  // tasks and expectation helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cpu(input logic [23:0] ad, input logic w, input logic wrd,
                     input logic [15:0] d);
    @(posedge pclk);
    req_valid <= 1;
    req <= '{ad, w, wrd, d};
    do begin
      @(posedge pclk);
    end while (rsp_valid !== 1'b1);
    req_valid <= 0;
  endtask
  task automatic do_reset(input logic pin);
    ea <= pin;
    strap_en <= 1;
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (8) @(posedge pclk);
    strap_en <= 0;
  endtask
  task automatic pulse_irq(input logic exp);
    @(posedge pclk);
    irq <= 1;
    @(posedge pclk);
    irq <= 0;
    @(negedge pclk);
    check(csp_save, exp);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] t, input logic sw, input logic rwd);
    return {16'h0, 5'h0, 1'b1, sw, 1'b0, t, rwd, 5'h0};
  endfunction
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    do_reset(0);
    apb(0, `EBMS_OFF_DCFG, 0);
    check({rq[10], rq[7:6]}, 3'b111);
    do_reset(1);
    apb(0, `EBMS_OFF_DCFG, 0);
    check(rq, 32'h00c0);
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(`EBMS_OFF_WCFG + 4 * i), 0);
      check(rq[9], 1'b0);
    end
    cpu(24'h200100, 0, 1, 0);
    @(negedge pclk);
    check({rsp_err, 8'(traps)}, 9'h101);
    apb(0, 8'h40, 0);
    check(re, 1'b1);
    // random round trips through every bus type
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      wd = r[8];
      a = {16'h2000, r[7:1], r[0] & ~wd};
      apb(1, `EBMS_OFF_DCFG, cfg(i[1:0], 1'b0, r[9]));
      cpu(a, 1, wd, r[31:16]);
      cpu(a, 0, wd, 0);
      if (wd) check(rsp_rdata, r[31:16]);
      else check(rsp_rdata[7:0], r[23:16]);
    end
    // demux window then mux default range
    apb(1, `EBMS_OFF_WADR, 32'h1000);
    apb(1, `EBMS_OFF_DCFG, cfg(2'b11, 1'b0, 1'b0));
    apb(1, `EBMS_OFF_WCFG, cfg(2'b10, 1'b0, 1'b0));
    cpu(24'h100010, 0, 1, 0);
    cpu(24'h200012, 0, 1, 0);
    check(ale_len, 2);
    check({aoe_seen, adr_seen}, 17'h10012);
    cpu(24'h200012, 0, 1, 0);
    check(ale_len, 1);
    // switch wait when leaving a mux window
    apb(1, `EBMS_OFF_WCFG, cfg(2'b11, 1'b1, 1'b0));
    cpu(24'h100010, 0, 1, 0);
    check(cs_n, 4'hd);
    cpu(24'h200012, 0, 1, 0);
    check(ale_len, 2);
    cpu(24'h200012, 0, 1, 0);
    check(ale_len, 1);
    check(seg, 6'h20);
    check(cs_n, 4'he);
    // switch wait into a demultiplexed default range
    apb(1, `EBMS_OFF_DCFG, cfg(2'b10, 1'b0, 1'b0));
    cpu(24'h100010, 0, 1, 0);
    cpu(24'h200012, 1, 1, 16'hbeef);
    cpu(24'h200012, 0, 1, 0);
    check(rsp_rdata, 16'hbeef);
    apb(1, `EBMS_OFF_CTRL, 0);
    pulse_irq(1);
    apb(1, `EBMS_OFF_CTRL, 1);
    pulse_irq(0);
    cpu(24'h200012, 0, 1, 0);
    check(seg, 6'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire
